/* dma_channel_mode_control.v */
/*
  Four-channel DMA channel mode control: channel control registers, address stepping,
  request source selection, request pin sensing and acknowledge generation, behind an
  Avalon-MM slave with waitrequest. Assumes an outside bus cycle engine that reports
  completed units and read/write phases; request pins arrive asynchronously.
*/
// Notes on behaviour
// - Four 16-bit control registers, zero on reset/standby.
// - Bits 7..5 writable only in channels 0, 1.
// - End flag: written zero clears, one ignored.
// - Destination step: fixed, increment, decrement; 11 illegal.
// - Single mode memory-to-device ignores destination step.
// - Source step: fixed, +1/+2, -1/-2; 11 illegal.
// - Single mode device-to-memory ignores source step.
// - Pin codes: dual, single out, single in.
// - On-chip serial, timer, auto, converter request codes.
// - Pin request sources only in channels 0, 1.
// - Acknowledge in read cycle or write cycle.
// - Acknowledge cycle bit ignored in single mode.
// - Acknowledge polarity: 0 high, 1 low.
// - Request pin sensed by low level or falling edge.
// - Unit size chooses byte or word step.
// - End flag set only on normal count end.
// - Transfer needs enables, no flags; clearing stops.
`timescale 1ns/1ps
`include "dma_channel_mode_control_regs.vh"

module dma_channel_mode_control #(
  parameter CHANNELS = 4,
  parameter PIN_CHANNELS = 2
) (
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire                   clk_en,
  input  wire                   standby,
  input  wire [6:0]             avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  output reg                    irq,
  input  wire [PIN_CHANNELS-1:0] transfer_request_in,
  output wire [PIN_CHANNELS-1:0] transfer_ack_out,
  input  wire [PIN_CHANNELS-1:0] cycle_read,
  input  wire [PIN_CHANNELS-1:0] cycle_write,
  input  wire                   serial0_rx_full_request,
  input  wire                   serial0_tx_empty_request,
  input  wire                   serial1_rx_full_request,
  input  wire                   serial1_tx_empty_request,
  input  wire                   timer0_match_a_request,
  input  wire                   timer1_match_a_request,
  input  wire                   timer2_match_a_request,
  input  wire                   timer3_match_a_request,
  input  wire                   adc_done_request,
  input  wire [CHANNELS-1:0]    unit_done,
  input  wire [CHANNELS-1:0]    count_zero,
  input  wire                   nmi_event,
  input  wire                   address_error_event,
  output reg  [CHANNELS-1:0]    request_pending
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Next address for one step mode; illegal mode 11 holds the address.
  function [31:0] step_addr;
    input [31:0] addr;
    input [1:0]  mode;
    input        word;
    reg   [31:0] size;
    begin
      size = word ? 32'h00000002 : 32'h00000001;
      case (mode)
        `STEP_INC: step_addr = addr + size;
        `STEP_DEC: step_addr = addr - size;
        default:   step_addr = addr;
      endcase
    end
  endfunction

  // Picks the request line that a source code names for a given channel.
  function pick_request;
    input [3:0] code;
    input       pin_ok;
    input       pin_req;
    input [8:0] chip;
    begin
      case (code)
        `RS_PIN_DUAL, `RS_PIN_MEM_TO_DEV, `RS_PIN_DEV_TO_MEM: pick_request = pin_ok & pin_req;
        `RS_SER0_RX: pick_request = chip[0];
        `RS_SER0_TX: pick_request = chip[1];
        `RS_SER1_RX: pick_request = chip[2];
        `RS_SER1_TX: pick_request = chip[3];
        `RS_TMR0:    pick_request = chip[4];
        `RS_TMR1:    pick_request = chip[5];
        `RS_TMR2:    pick_request = chip[6];
        `RS_TMR3:    pick_request = chip[7];
        `RS_AUTO:    pick_request = 1'b1;
        `RS_ADC:     pick_request = chip[8];
        default:     pick_request = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus slave handshake
  // ----------------------------------------------------------------
  wire                  bus_req  = avs_read | avs_write;
  wire                  wr_fire  = avs_write & ~avs_waitrequest;
  wire                  in_chan  = ~avs_address[6];
  wire [1:0]            chan_sel = avs_address[5:4];
  wire [1:0]            reg_sel  = avs_address[3:2];
  wire                  top_ok   = avs_address[6] & (avs_address[5:4] == 2'h0);
  wire [8:0]            chip_req = {adc_done_request, timer3_match_a_request, timer2_match_a_request,
                                    timer1_match_a_request, timer0_match_a_request, serial1_tx_empty_request,
                                    serial1_rx_full_request, serial0_tx_empty_request, serial0_rx_full_request};
  wire [CHANNELS*16-1:0] ctrl_all;
  wire [CHANNELS*32-1:0] src_all;
  wire [CHANNELS*32-1:0] dst_all;
  wire [CHANNELS-1:0]   end_event;
  wire [CHANNELS-1:0]   next_pending;
  reg  [2:0]            operation;
  reg  [CHANNELS-1:0]   irq_status;
  reg  [CHANNELS-1:0]   irq_enable;
  reg  [31:0]           next_readdata;

  // Abort flags block every channel; master enable gates them all.
  wire                  global_ok = operation[`MASTER_ENABLE_BIT] & ~operation[`NMI_FLAG_BIT] &
                                    ~operation[`ADDR_ERR_FLAG_BIT];

  // A request is held one cycle with waitrequest high, then answered; writes land on the answer edge.
  always @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (clk_en) begin
      if (bus_req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? next_readdata : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets and the clear register read as zero.
  always @* begin
    next_readdata = 32'h00000000;
    if (in_chan) begin
      case (reg_sel)
        2'h0:    next_readdata = {16'h0000, ctrl_all[chan_sel*16 +: 16]};
        2'h1:    next_readdata = src_all[chan_sel*32 +: 32];
        2'h2:    next_readdata = dst_all[chan_sel*32 +: 32];
        default: next_readdata = 32'h00000000;
      endcase
    end else if (top_ok) begin
      case (reg_sel)
        2'h0:    next_readdata = {29'h00000000, operation};
        2'h1:    next_readdata = {{(32-CHANNELS){1'b0}}, irq_status};
        2'h2:    next_readdata = {{(32-CHANNELS){1'b0}}, irq_enable};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation register, interrupt status and enable
  // ----------------------------------------------------------------

  // Hardware events win over a software clear in the same cycle.
  always @(posedge sys_clk) begin
    if (reset | standby) begin
      operation  <= `OPERATION_RESET;
      irq_status <= {CHANNELS{1'b0}};
      irq_enable <= {CHANNELS{1'b0}};
      irq        <= 1'b0;
      request_pending <= {CHANNELS{1'b0}};
    end else if (clk_en) begin
      if (wr_fire & top_ok & (reg_sel == 2'h0)) begin
        operation[`MASTER_ENABLE_BIT] <= avs_writedata[`MASTER_ENABLE_BIT];
        if (~avs_writedata[`NMI_FLAG_BIT])
          operation[`NMI_FLAG_BIT] <= 1'b0;
        if (~avs_writedata[`ADDR_ERR_FLAG_BIT])
          operation[`ADDR_ERR_FLAG_BIT] <= 1'b0;
      end
      if (nmi_event)
        operation[`NMI_FLAG_BIT] <= 1'b1;
      if (address_error_event)
        operation[`ADDR_ERR_FLAG_BIT] <= 1'b1;
      if (wr_fire & top_ok & (reg_sel == 2'h2))
        irq_enable <= avs_writedata[CHANNELS-1:0];
      if (wr_fire & top_ok & (reg_sel == 2'h3))
        irq_status <= (irq_status & ~avs_writedata[CHANNELS-1:0]) | end_event;
      else
        irq_status <= irq_status | end_event;
      irq             <= |(irq_status & irq_enable);
      request_pending <= next_pending;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel control, stepping and request selection
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : gen_ch
      reg  [15:0] ctrl;
      reg  [31:0] src_addr;
      reg  [31:0] dst_addr;
      reg  [2:0]  pin_sync;
      reg         pin_level;
      reg         edge_pend;
      wire        pin_ok   = (i < PIN_CHANNELS);
      wire        ctrl_hit = wr_fire & in_chan & (chan_sel == i) & (reg_sel == 2'h0);
      wire        src_hit  = wr_fire & in_chan & (chan_sel == i) & (reg_sel == 2'h1);
      wire        dst_hit  = wr_fire & in_chan & (chan_sel == i) & (reg_sel == 2'h2);
      wire [3:0]  rs       = ctrl[`REQ_SRC_HI:`REQ_SRC_LO];
      wire        active   = ctrl[`CHAN_ENABLE_BIT] & ~ctrl[`END_FLAG_BIT] & global_ok;
      wire        pin_req  = ctrl[`REQ_SENSE_BIT] ? edge_pend : ~pin_level;
      wire        done     = unit_done[i] & active;
      wire [15:0] keep_mask = pin_ok ? 16'hffff : ~`CTRL_PIN_BITS_MASK;

      assign ctrl_all[i*16 +: 16] = ctrl;
      assign src_all[i*32 +: 32]  = src_addr;
      assign dst_all[i*32 +: 32]  = dst_addr;
      assign end_event[i]         = done & count_zero[i];
      assign next_pending[i]      = active & pick_request(rs, pin_ok, pin_req, chip_req);

      // Control register; the end flag is set by hardware and cleared only by a written zero.
      // The request source is taken as written; software keeps it steady while enabled.
      always @(posedge sys_clk) begin
        if (reset | standby) begin
          ctrl <= `CTRL_RESET;
        end else if (clk_en) begin
          if (ctrl_hit) begin
            ctrl <= (avs_writedata[15:0] & keep_mask & ~16'h0002) | (ctrl & 16'h0002);
            if (~avs_writedata[`END_FLAG_BIT])
              ctrl[`END_FLAG_BIT] <= 1'b0;
          end
          if (end_event[i])
            ctrl[`END_FLAG_BIT] <= 1'b1;
        end
      end

      // Working addresses step after each unit; a bus write in the same cycle wins.
      // Single mode leaves the address that faces the acknowledged device untouched.
      always @(posedge sys_clk) begin
        if (reset) begin
          src_addr <= 32'h00000000;
          dst_addr <= 32'h00000000;
        end else if (clk_en) begin
          if (src_hit)
            src_addr <= avs_writedata;
          else if (done & ~(pin_ok & (rs == `RS_PIN_DEV_TO_MEM)))
            src_addr <= step_addr(src_addr, ctrl[`SRC_STEP_HI:`SRC_STEP_LO], ctrl[`UNIT_SIZE_BIT]);
          if (dst_hit)
            dst_addr <= avs_writedata;
          else if (done & ~(pin_ok & (rs == `RS_PIN_MEM_TO_DEV)))
            dst_addr <= step_addr(dst_addr, ctrl[`DST_STEP_HI:`DST_STEP_LO], ctrl[`UNIT_SIZE_BIT]);
        end
      end

      // Pin synchroniser: the level counts once stages two and three agree.
      // A falling edge is held until a unit completes or the channel enable bit is cleared; a new edge wins.
      always @(posedge sys_clk) begin
        if (reset) begin
          pin_sync  <= 3'h7;
          pin_level <= 1'b1;
          edge_pend <= 1'b0;
        end else if (clk_en) begin
          pin_sync <= {pin_sync[1:0], pin_ok ? transfer_request_in[i % PIN_CHANNELS] : 1'b1};
          if (pin_sync[1] == pin_sync[2])
            pin_level <= pin_sync[2];
          if ((pin_sync[1] == pin_sync[2]) & pin_level & ~pin_sync[2])
            edge_pend <= 1'b1;
          else if (done | ~ctrl[`CHAN_ENABLE_BIT])
            edge_pend <= 1'b0;
        end
      end

      // Acknowledge pin: phase chosen in dual mode, whole cycle in single mode, then polarity.
      if (i < PIN_CHANNELS) begin : gen_ack
        wire single = (rs == `RS_PIN_MEM_TO_DEV) | (rs == `RS_PIN_DEV_TO_MEM);
        wire pin_src = (rs == `RS_PIN_DUAL) | single;
        wire ack_on = active & pin_src & (single ? (cycle_read[i] | cycle_write[i]) :
                      (ctrl[`ACK_CYCLE_BIT] ? cycle_write[i] : cycle_read[i]));
        reg  ack_q;

        // Each channel owns its own flip-flop, so the output bus has one driver per bit.
        assign transfer_ack_out[i] = ack_q;
        always @(posedge sys_clk) begin
          if (reset) begin
            ack_q <= 1'b0;
          end else if (clk_en) begin
            ack_q <= ack_on ^ ctrl[`ACK_POLARITY_BIT];
          end
        end
      end
    end
  endgenerate

endmodule

/* dma_channel_mode_control_regs.vh */
/*
  Register offsets, field positions and reset values of the DMA channel mode control block.
  Assumes inclusion by bare name from the design file; holds definitions only.
*/
`ifndef DMA_CHANNEL_MODE_CONTROL_REGS_VH
`define DMA_CHANNEL_MODE_CONTROL_REGS_VH

// ----------------------------------------------------------------
// Byte offsets (channel n adds n times the channel stride)
// ----------------------------------------------------------------
`define OFS_CHANNEL_CONTROL  7'h00
`define OFS_SRC_ADDR         7'h04
`define OFS_DST_ADDR         7'h08
`define CHANNEL_STRIDE       7'h10
`define OFS_OPERATION        7'h40
`define OFS_IRQ_STATUS       7'h44
`define OFS_IRQ_ENABLE       7'h48
`define OFS_IRQ_CLEAR        7'h4c

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define DST_STEP_HI          15
`define DST_STEP_LO          14
`define SRC_STEP_HI          13
`define SRC_STEP_LO          12
`define REQ_SRC_HI           11
`define REQ_SRC_LO           8
`define ACK_CYCLE_BIT        7
`define ACK_POLARITY_BIT     6
`define REQ_SENSE_BIT        5
`define BURST_BIT            4
`define UNIT_SIZE_BIT        3
`define END_IRQ_EN_BIT       2
`define END_FLAG_BIT         1
`define CHAN_ENABLE_BIT      0
`define CTRL_RESET           16'h0000
`define CTRL_PIN_BITS_MASK   16'h00e0

// ----------------------------------------------------------------
// Operation register fields and reset value
// ----------------------------------------------------------------
`define MASTER_ENABLE_BIT    0
`define NMI_FLAG_BIT         1
`define ADDR_ERR_FLAG_BIT    2
`define OPERATION_RESET      3'h0

// ----------------------------------------------------------------
// Step modes and request source codes
// ----------------------------------------------------------------
`define STEP_FIXED           2'h0
`define STEP_INC             2'h1
`define STEP_DEC             2'h2
`define RS_PIN_DUAL          4'h0
`define RS_PIN_MEM_TO_DEV    4'h2
`define RS_PIN_DEV_TO_MEM    4'h3
`define RS_SER0_RX           4'h4
`define RS_SER0_TX           4'h5
`define RS_SER1_RX           4'h6
`define RS_SER1_TX           4'h7
`define RS_TMR0              4'h8
`define RS_TMR1              4'h9
`define RS_TMR2              4'ha
`define RS_TMR3              4'hb
`define RS_AUTO              4'hc
`define RS_ADC               4'hd

`endif

/* dma_channel_mode_control_props.sv */
/* Port-level checks of the DMA channel mode control block, with its bind.
   Assumes one clock, a synchronous active-high reset and one bus wait cycle. */
`timescale 1ns/1ps
module dma_channel_mode_control_props #(
  parameter CHANNELS     = 4,
  parameter PIN_CHANNELS = 2
) (
  input logic                    sys_clk,
  input logic                    reset,
  input logic                    clk_en,
  input logic                    standby,
  input logic [6:0]              avs_address,
  input logic                    avs_read,
  input logic                    avs_write,
  input logic [31:0]             avs_readdata,
  input logic                    avs_waitrequest,
  input logic                    irq,
  input logic [PIN_CHANNELS-1:0] transfer_ack_out,
  input logic [PIN_CHANNELS-1:0] cycle_read,
  input logic [PIN_CHANNELS-1:0] cycle_write,
  input logic [CHANNELS-1:0]     unit_done,
  input logic [CHANNELS-1:0]     count_zero,
  input logic                    nmi_event,
  input logic                    address_error_event,
  input logic [CHANNELS-1:0]     request_pending
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Completed reads and normal transfer ends, shared by several checks.
  wire                rd_done = avs_read && !avs_waitrequest;
  wire [CHANNELS-1:0] ends    = unit_done & count_zero;
  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_CTRL_UPPER: assert property (rd_done && avs_address[3:2] == 2'h0 && !avs_address[6] |-> avs_readdata[31:16] == 16'h0)
    else $error("control register wider than sixteen bits");
  AST_PIN_BITS: assert property (rd_done && avs_address[3:2] == 2'h0 && avs_address[6:5] == 2'h1 |-> avs_readdata[7:5] == 3'h0)
    else $error("pin bits of channel two or three not zero");
  AST_UNMAPPED: assert property (rd_done && (avs_address[3:2] == 2'h3 || avs_address[6:4] > 3'h4) |-> avs_readdata == 32'h0)
    else $error("unmapped or clear address read nonzero");
  AST_FLAG_STOPS: assert property ((nmi_event || address_error_event) && clk_en |-> ##2 request_pending == '0)
    else $error("request pending after abort event");
  AST_END_STOPS: assert property (|ends && clk_en |-> ##2 (request_pending & $past(ends, 2)) == '0)
    else $error("request pending after transfer end");
  AST_ACK_CAUSE: assert property ($changed(transfer_ack_out) |-> $past(cycle_read) != $past(cycle_read, 2) ||
    $past(cycle_write) != $past(cycle_write, 2) || $past(avs_write) || $past(avs_write, 2) || $past(standby) ||
    $past(standby, 2) || $past(nmi_event || address_error_event, 2) || $past(|ends, 2))
    else $error("acknowledge changed without a cause");
  AST_STANDBY_IRQ: assert property (standby && clk_en |-> ##2 !irq)
    else $error("interrupt survives standby");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(|ends, 2) || $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt rose without transfer end or enable write");
  // Main scenarios reached by the bench.
  cover property (|ends);
  cover property ($fell(transfer_ack_out[0]));
  cover property (nmi_event ##2 request_pending == '0);
endmodule

bind dma_channel_mode_control dma_channel_mode_control_props #(.CHANNELS(CHANNELS), .PIN_CHANNELS(PIN_CHANNELS))
  u_props (.sys_clk, .reset, .clk_en, .standby, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .irq, .transfer_ack_out, .cycle_read, .cycle_write, .unit_done, .count_zero, .nmi_event,
  .address_error_event, .request_pending);

/* dma_req_peer.sv */
/* Far-side peripheral model driving one request pin.
   Assumes the bench changes want and pulse_mode just after a rising edge. */
`timescale 1ns/1ps
module dma_req_peer (
  input  wire sys_clk,
  input  wire want,
  input  wire pulse_mode,
  output reg  pin
);
  reg [1:0] cnt = 2'h0;
  initial pin = 1'b1;
  // ------------------------------------------------------------
  // Request pin
  // ------------------------------------------------------------
  // Level mode holds the pin low while wanted; pulse mode gives a three-cycle fall.
  // The pin idles high, so a released pin never shows a stale low.
  always @(posedge sys_clk) begin
    cnt <= want ? ((cnt != 2'h3) ? cnt + 2'h1 : cnt) : 2'h0;
    pin <= !(want && (!pulse_mode || cnt != 2'h3));
  end
endmodule

/* testbench.sv */
/* Self-checking bench for the DMA channel mode control block.
   Assumes the register header beside it and the peer model for the request pins. */
`timescale 1ns/1ps
`include "dma_channel_mode_control_regs.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         reset = 1'b1;
  reg         standby = 1'b0;
  reg         clk_en = 1'b1;
  reg  [6:0]  avs_address = 7'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        irq;
  reg  [1:0]  want = 2'h0;
  reg  [1:0]  pulse = 2'h0;
  reg  [1:0]  cycle_read = 2'h0;
  reg  [1:0]  cycle_write = 2'h0;
  reg  [8:0]  onchip = 9'h0;
  reg  [8:0]  sel;
  reg  [3:0]  unit_done = 4'h0;
  reg  [3:0]  count_zero = 4'h0;
  reg         nmi_event = 1'b0;
  reg         address_error_event = 1'b0;
  wire [1:0]  pins;
  wire [1:0]  ack;
  wire [3:0]  pend;
  reg  [31:0] rd;
  integer     fails = 0;
  integer     checks_done = 0;
  integer     i;
  wire [31:0] ack0 = {31'h0, ack[0]};
  wire [31:0] ack32 = {30'h0, ack};
  wire [31:0] pend32 = {28'h0, pend};
  wire [31:0] irq32 = {31'h0, irq};
  // 40 MHz system clock.
  always #12.5 sys_clk = ~sys_clk;
  dma_channel_mode_control u_dut (.sys_clk, .reset, .clk_en, .standby, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .transfer_request_in(pins),
    .transfer_ack_out(ack), .cycle_read, .cycle_write, .serial0_rx_full_request(onchip[0]),
    .serial0_tx_empty_request(onchip[1]), .serial1_rx_full_request(onchip[2]), .serial1_tx_empty_request(onchip[3]),
    .timer0_match_a_request(onchip[4]), .timer1_match_a_request(onchip[5]), .timer2_match_a_request(onchip[6]),
    .timer3_match_a_request(onchip[7]), .adc_done_request(onchip[8]), .unit_done, .count_zero, .nmi_event,
    .address_error_event, .request_pending(pend));
  dma_req_peer u_peer0 (.sys_clk(sys_clk), .want(want[0]), .pulse_mode(pulse[0]), .pin(pins[0]));
  dma_req_peer u_peer1 (.sys_clk(sys_clk), .want(want[1]), .pulse_mode(pulse[1]), .pin(pins[1]));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One bus access; two idle edges follow, so registered outputs that the access changed have settled
  // before the caller looks at them, and the next request never rises in the same step.
  task bus(input [6:0] a, input w, input [31:0] d);
    integer n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk({31'h0, n == 1}, 32'h1);
    end
  endtask
  task rchk(input [6:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(rd, e);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task unit(input [3:0] m, input z);
    begin
      unit_done <= m;
      count_zero <= z ? m : 4'h0;
      @(posedge sys_clk);
      unit_done <= 4'h0;
      count_zero <= 4'h0;
      @(posedge sys_clk);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rchk({i[2:0], 4'h0}, 32'h0);
        bus({i[2:0], 4'h0}, 1'b1, 32'hffff_fffe);
        rchk({i[2:0], 4'h0}, (i < 2) ? 32'hfffc : 32'hff1c);
      end
      standby <= 1'b1;
      tick(1);
      standby <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        rchk({i[2:0], 4'h0}, 32'h0);
      rchk(7'h0c, 32'h0);
    end
  endtask
  task t_step;
    begin
      bus(`OFS_OPERATION, 1'b1, 32'h1);
      bus(7'h24, 1'b1, 32'h100);
      bus(7'h28, 1'b1, 32'h200);
      bus(7'h20, 1'b1, 32'h6c08);
      bus(7'h20, 1'b1, 32'h6c09);
      chk(pend32, 32'h4);
      unit(4'h4, 1'b0);
      rchk(7'h24, 32'hfe);
      rchk(7'h28, 32'h202);
      bus(7'h20, 1'b1, 32'h8c01);
      unit(4'h4, 1'b0);
      rchk(7'h24, 32'hfe);
      rchk(7'h28, 32'h201);
      bus(7'h20, 1'b1, 32'hfc01);
      bus(`OFS_IRQ_ENABLE, 1'b1, 32'h4);
      unit(4'h4, 1'b1);
      rchk(7'h28, 32'h201);
      rchk(7'h20, 32'hfc03);
      rchk(`OFS_IRQ_STATUS, 32'h4);
      chk(irq32, 32'h1);
      chk(pend32, 32'h0);
      bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0);
      chk(irq32, 32'h0);
      bus(`OFS_IRQ_ENABLE, 1'b1, 32'h4);
      bus(`OFS_IRQ_CLEAR, 1'b1, 32'h4);
      rchk(`OFS_IRQ_STATUS, 32'h0);
      chk(irq32, 32'h0);
      bus(7'h20, 1'b1, 32'hfc01);
      rchk(7'h20, 32'hfc01);
    end
  endtask
  // Every source code on channel two, with only its own request raised and then all but it.
  task t_onchip;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        sel = (i >= 4 && i < 12) ? (9'h1 << (i - 4)) : ((i == 13) ? 9'h100 : 9'h0);
        bus(7'h20, 1'b1, {20'h0, i[3:0], 8'h00});
        bus(7'h20, 1'b1, {20'h0, i[3:0], 8'h01});
        onchip <= sel;
        tick(2);
        chk(pend32, (i >= 4 && i <= 13) ? 32'h4 : 32'h0);
        onchip <= ~sel;
        tick(2);
        chk(pend32, (i == 12) ? 32'h4 : 32'h0);
      end
      onchip <= 9'h0;
    end
  endtask
  task t_pin;
    begin
      bus(7'h00, 1'b1, 32'h0001);
      want[0] <= 1'b1;
      tick(8);
      chk(pend32, 32'h1);
      want[0] <= 1'b0;
      tick(8);
      chk(pend32, 32'h0);
      bus(7'h00, 1'b1, 32'h0021);
      pulse[0] <= 1'b1;
      want[0] <= 1'b1;
      tick(10);
      chk(pend32, 32'h1);
      unit(4'h1, 1'b0);
      tick(1);
      chk(pend32, 32'h0);
      want[0] <= 1'b0;
      pulse[0] <= 1'b0;
      bus(7'h10, 1'b1, 32'h0040);
      bus(7'h00, 1'b1, 32'h0041);
      chk(ack32, 32'h3);
      cycle_read[0] <= 1'b1;
      tick(2);
      chk(ack0, 32'h0);
      cycle_read[0] <= 1'b0;
      cycle_write[0] <= 1'b1;
      tick(2);
      chk(ack0, 32'h1);
      bus(7'h00, 1'b1, 32'h00c1);
      chk(ack0, 32'h0);
      cycle_write[0] <= 1'b0;
      bus(7'h00, 1'b1, 32'h5280);
      bus(7'h00, 1'b1, 32'h5281);
      cycle_read[0] <= 1'b1;
      tick(2);
      chk(ack0, 32'h1);
      cycle_read[0] <= 1'b0;
      bus(7'h04, 1'b1, 32'h100);
      bus(7'h08, 1'b1, 32'h200);
      unit(4'h1, 1'b0);
      rchk(7'h04, 32'h101);
      rchk(7'h08, 32'h200);
      bus(7'h00, 1'b1, 32'h5380);
      bus(7'h00, 1'b1, 32'h5381);
      unit(4'h1, 1'b0);
      rchk(7'h04, 32'h101);
      rchk(7'h08, 32'h201);
      clk_en <= 1'b0;
      unit(4'h1, 1'b0);
      clk_en <= 1'b1;
      rchk(7'h08, 32'h201);
    end
  endtask
  task t_abort;
    begin
      bus(7'h20, 1'b1, 32'h0c00);
      bus(7'h20, 1'b1, 32'h0c01);
      nmi_event <= 1'b1;
      tick(1);
      nmi_event <= 1'b0;
      tick(2);
      chk(pend32, 32'h0);
      rchk(`OFS_OPERATION, 32'h3);
      bus(`OFS_OPERATION, 1'b1, 32'h1);
      chk(pend32, 32'h4);
      address_error_event <= 1'b1;
      tick(1);
      address_error_event <= 1'b0;
      rchk(`OFS_OPERATION, 32'h5);
      chk(pend32, 32'h0);
      bus(`OFS_OPERATION, 1'b1, 32'h1);
      bus(7'h20, 1'b1, 32'h0c00);
      chk(pend32, 32'h0);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_step;
    t_onchip;
    t_pin;
    t_abort;
    print_verdict;
  end
  // Watchdog at about forty times the expected run.
  initial begin
    #500000;
    fails = fails + 1;
    print_verdict;
  end
endmodule
